// ===== hdl/sto_pkg.sv
// Purpose: constants and types for the two-channel torque-off controller
// Assumes: pclk at 250 MHz, registers reached over APB with 32-bit data
// Notes:   every offset, register reset value and timing count is named here once
package sto_pkg;

   // clock and timing
   localparam int unsigned CLK_MHZ         = 250;
   localparam int unsigned MON_CYCLE_US    = 4000;   // monitoring cycle
   localparam int unsigned MON_CYCLES      = CLK_MHZ * MON_CYCLE_US;
   localparam int unsigned HUNDREDTH_H_US  = 36_000_000; // 0.01 hour
   localparam int unsigned HUNDREDTH_TICKS = HUNDREDTH_H_US / MON_CYCLE_US;

   // register byte offsets
   localparam logic [7:0] ADDR_CFG_A  = 8'h00;
   localparam logic [7:0] ADDR_CFG_B  = 8'h04;
   localparam logic [7:0] ADDR_TEST   = 8'h08;
   localparam logic [7:0] ADDR_CMD    = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_TIMER  = 8'h14;

   // field positions and values
   localparam int unsigned EN_TERM_BIT = 0;
   localparam int unsigned EN_EXT_BIT  = 2;
   localparam int unsigned EN_FB_BIT   = 3;
   localparam int unsigned CMD_ACK_BIT = 0;
   localparam logic [19:0] TEST_MAX    = 20'hdbba0; // 9000.00 h
   localparam logic [19:0] TEST_RST    = 20'h00320; // 8.00 h
   localparam logic [31:0] CFG_RST     = 32'h00000000;

   // single-channel discrepancy message class
   typedef enum logic [1:0] {MSG_NONE, MSG_ALARM, MSG_FAULT} sto_msgm_t;

   // restart sequence
   typedef enum logic [1:0] {RUN_INHIBIT, RUN_READY, RUN_ON} sto_run_t;

   // per-channel configuration word
   typedef struct packed {
      logic [5:0] rsv_hi;   // reads zero
      sto_msgm_t  msgm;     // discrepancy message class
      logic [7:0] disc;     // discrepancy time, monitor cycles
      logic [7:0] deb;      // debounce time, monitor cycles
      logic [1:0] rsv_lo;   // reads zero
      logic       brake;    // brake drive enabled
      logic       wdraw;    // message withdraw bit
      logic [3:0] en;       // enable field
   } sto_cfg_t;

   // drive-facing outputs
   typedef struct packed {
      logic pulse_off_a;    // channel a switch-off path
      logic pulse_off_b;    // channel b switch-off path
      logic pulse_suppress; // combined pulse suppression
      logic brake_close;    // close holding brake
      logic inhibit;        // switching-on inhibit
      logic coast_stop;     // coast stop command
      logic arm_short;      // armature short-circuit active
      logic drive_on;       // drive switched on
      logic test_alarm;     // switch-off path test overdue
   } sto_drive_t;

endpackage

// ===== hdl/sto_ctrl.sv
// Purpose: two-channel torque-off controller with test interval timer
// Assumes: terminal and on/off pins are asynchronous; fieldbus selects,
//          enables and requests come from logic on pclk
// Notes:   APB slave answers with zero wait states
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sto_ctrl #(
   parameter int unsigned MON_CYCLES      = sto_pkg::MON_CYCLES,
   parameter int unsigned HUNDREDTH_TICKS = sto_pkg::HUNDREDTH_TICKS
) (
   input  wire logic        pclk,            // 250 MHz clock
   input  wire logic        presetn,         // async reset, active low
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb access phase
   input  wire logic        pwrite,          // apb write
   input  wire logic [7:0]  paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic [31:0]      prdata,          // apb read data
   output logic             pready,          // apb ready
   output logic             pslverr,         // apb error
   input  wire logic        term_sel_n_a,    // channel a terminal, low sel
   input  wire logic        term_sel_n_b,    // channel b terminal, low sel
   input  wire logic [1:0]  fb_sel,          // fieldbus select per channel
   input  wire logic        startup_done,    // system fully started
   input  wire logic        brake_present,   // brake connected
   input  wire logic        drive_enable,    // drive enables issued
   input  wire logic        on_off_command,  // on/off pin
   input  wire logic        arm_short_req,   // armature short request
   input  wire logic        deact_req,       // component deactivate pulse
   output logic             deact_done,      // deactivation granted pulse
   output logic             deact_refused,   // deactivation refused pulse
   output sto_pkg::sto_drive_t drv           // drive-facing outputs
);
   import sto_pkg::*;

   // complete state of the block
   typedef struct packed {
      logic [2:0]      sync1;      // first synchroniser stage
      logic [2:0]      sync2;      // second synchroniser stage
      sto_cfg_t [1:0]  cfg;        // per-channel configuration
      logic [19:0]     test_set;   // test interval setting
      logic [19:0]     timer;      // remaining hundredths of hour
      logic [19:0]     mon_div;    // monitor cycle divider
      logic [13:0]     hh_div;     // hundredth-hour prescaler
      logic [1:0]      deb_lvl;    // debounced terminal selection
      logic [1:0][7:0] deb_cnt;    // debounce counters
      logic [7:0]      disc_cnt;   // discrepancy counter
      logic            disc_done;  // discrepancy already reported
      logic            started;    // startup completed
      logic [1:0]      sel;        // effective channel selection
      logic            sto_q;      // torque-off active last cycle
      logic            safety_msg; // pending safety message
      logic            fault;      // logged fault entry
      logic [1:0]      stop_pend;  // pending stop per channel
      sto_run_t        run;        // restart sequence state
      logic            on_off_q;   // on/off edge detect
      logic [31:0]     rdata;      // read data for access phase
      logic            err;        // error for access phase
      logic            dn;         // deactivation granted
      logic            rf;         // deactivation refused
      sto_drive_t      out;        // registered drive outputs
   } sto_state_t;

   sto_state_t s_q;   // registered state
   sto_state_t s_d;   // next state

   // combinational helpers
   logic        mon_tick;   // one monitoring cycle elapsed
   logic        hh_tick;    // one hundredth hour elapsed
   logic        term_en;    // terminal selection enabled
   logic        fb_en;      // fieldbus selection enabled
   logic        ext_fn;     // extended functions chosen
   logic        any_en;     // any safety function enabled
   logic [1:0]  raw_sel;    // selected level at terminals
   logic [1:0]  sel_now;    // selection this cycle
   logic        sto_now;    // torque-off selected
   logic        sto_fall;   // deselection event
   logic        sto_edge;   // selection or deselection
   logic        diff;       // channels disagree
   logic [7:0]  disc_lim;   // discrepancy window
   logic        disc_hit;   // window exceeded
   logic        setup;      // apb setup phase
   logic        access;     // apb access phase
   logic        on_fall;    // on/off falling edge
   logic        on_rise;    // on/off rising edge

   // zero wait state slave, data comes from the setup-phase flops
   assign pready  = 1'b1;
   assign prdata  = s_q.rdata;
   assign pslverr = s_q.err;
   assign deact_done    = s_q.dn;
   assign deact_refused = s_q.rf;
   assign drv     = s_q.out;

   // next-state logic
   always_comb begin
      s_d = s_q;
      setup  = psel & ~penable;
      access = psel & penable;

      // pins pass two flops before any logic reads them
      s_d.sync1 = {on_off_command, ~term_sel_n_b, ~term_sel_n_a};
      s_d.sync2 = s_q.sync1;
      raw_sel   = s_q.sync2[1:0];
      on_fall   = s_q.on_off_q & ~s_q.sync2[2];
      on_rise   = ~s_q.on_off_q & s_q.sync2[2];
      s_d.on_off_q = s_q.sync2[2];

      // monitoring cycle enable from the divider
      mon_tick = (s_q.mon_div == 20'(MON_CYCLES - 1));
      s_d.mon_div = mon_tick ? 20'h00000 : s_q.mon_div + 20'h00001;

      // enable decoding needs agreement of both channels, except any_en which takes either channel
      term_en = s_q.cfg[0].en[EN_TERM_BIT] & s_q.cfg[1].en[EN_TERM_BIT];
      fb_en   = s_q.cfg[0].en[EN_FB_BIT] & s_q.cfg[1].en[EN_FB_BIT];
      ext_fn  = s_q.cfg[0].en[EN_EXT_BIT] & s_q.cfg[1].en[EN_EXT_BIT];
      any_en  = (|s_q.cfg[0].en) | (|s_q.cfg[1].en);

      // debounce: a new level is taken once stable long enough
      for (int i = 0; i < 2; i++) begin
         if (raw_sel[i] == s_q.deb_lvl[i]) begin
            s_d.deb_cnt[i] = 8'h00;
         end else if (s_q.deb_cnt[i] >= s_q.cfg[i].deb) begin
            s_d.deb_lvl[i] = raw_sel[i];
            s_d.deb_cnt[i] = 8'h00;
         end else if (mon_tick) begin
            s_d.deb_cnt[i] = s_q.deb_cnt[i] + 8'h01;
         end
      end

      // startup latch; until then both paths stay selected
      if (startup_done) begin
         s_d.started = 1'b1;
      end
      if (!s_q.started) begin
         sel_now = 2'b11;
      end else begin
         sel_now = ({2{term_en}} & s_q.deb_lvl) | ({2{fb_en}} & fb_sel);
      end
      s_d.sel  = sel_now;
      sto_now  = |sel_now;
      s_d.sto_q = sto_now;
      sto_fall = s_q.sto_q & ~sto_now;      // internal acknowledgement
      sto_edge = s_q.sto_q ^ sto_now;

      // discrepancy supervision with the longer channel window
      diff     = sel_now[0] ^ sel_now[1];
      disc_lim = (s_q.cfg[0].disc > s_q.cfg[1].disc) ?
                 s_q.cfg[0].disc : s_q.cfg[1].disc;
      disc_hit = diff & ~s_q.disc_done & (s_q.disc_cnt >= disc_lim);
      if (!diff) begin
         s_d.disc_cnt  = 8'h00;
         s_d.disc_done = 1'b0;
      end else if (disc_hit) begin
         s_d.disc_done = 1'b1;
      end else if (mon_tick) begin
         s_d.disc_cnt = s_q.disc_cnt + 8'h01;
      end

      // pending stops drop on deselection, new ones win
      if (sto_fall) begin
         s_d.stop_pend = 2'b00;
      end
      // safety messages withdrawn on either edge if enabled
      if (sto_edge && (s_q.cfg[0].wdraw || s_q.cfg[1].wdraw)) begin
         s_d.safety_msg = 1'b0;
      end
      // faults only go on acknowledgement with the cause removed
      if (access && pwrite && paddr == ADDR_CMD &&
          pwdata[CMD_ACK_BIT] && !diff) begin
         s_d.fault = 1'b0;
      end
      // discrepancy report by configured class; silent by default
      if (disc_hit) begin
         case (s_q.cfg[0].msgm)
            MSG_ALARM: begin
               s_d.safety_msg = 1'b1;
            end
            MSG_FAULT: begin
               s_d.fault     = 1'b1;
               s_d.stop_pend = 2'b11;
            end
            default: begin
            end
         endcase
      end

      // hundredth-hour prescaler runs only while deselected
      hh_tick = 1'b0;
      if (!sto_now && mon_tick) begin
         hh_tick = (s_q.hh_div == 14'(HUNDREDTH_TICKS - 1));
         s_d.hh_div = hh_tick ? 14'h0000 : s_q.hh_div + 14'h0001;
      end

      // test interval timer and overdue alarm
      if (sto_fall) begin
         s_d.timer = s_q.test_set;
         s_d.out.test_alarm = 1'b0;               // test performed
      end else if (s_q.timer == 20'h00000) begin
         s_d.out.test_alarm = ~sto_now | s_q.out.test_alarm;
      end else if (hh_tick) begin
         s_d.timer = s_q.timer - 20'h00001;
      end

      // restart sequence; deselection alone never switches on
      case (s_q.run)
         RUN_INHIBIT: begin
            // on/off falling edge clears the inhibit
            if (!sto_now && drive_enable && on_fall) begin
               s_d.run = RUN_READY;
            end
         end
         RUN_READY: begin
            if (sto_now) begin
               s_d.run = RUN_INHIBIT;
            end else if (drive_enable && on_rise) begin
               s_d.run = RUN_ON;
            end
         end
         RUN_ON: begin
            if (sto_now) begin
               s_d.run = RUN_INHIBIT;
            end else if (!drive_enable) begin
               s_d.run = RUN_READY;
            end
         end
         default: begin
            s_d.run = RUN_INHIBIT;
         end
      endcase
      if (sto_now) begin
         s_d.run = RUN_INHIBIT;
      end

      // drive outputs; the test alarm feeds none of them
      s_d.out.pulse_off_a    = sel_now[0];
      s_d.out.pulse_off_b    = sel_now[1];
      s_d.out.pulse_suppress = sel_now[0] | sel_now[1];
      s_d.out.brake_close    = sto_now & brake_present &
                               s_q.cfg[0].brake & s_q.cfg[1].brake;
      s_d.out.inhibit        = (s_d.run == RUN_INHIBIT);
      s_d.out.drive_on       = (s_d.run == RUN_ON);
      s_d.out.coast_stop     = sto_now;
      s_d.out.arm_short      = arm_short_req & ~sto_now;

      // component deactivation is refused while enabled
      s_d.dn = deact_req & ~any_en;
      s_d.rf = deact_req & any_en;

      // apb write at the access phase
      if (access && pwrite) begin
         if (paddr == ADDR_CFG_A) begin
            s_d.cfg[0] = sto_cfg_t'(pwdata & 32'h03ffff3f);
         end else if (paddr == ADDR_CFG_B) begin
            s_d.cfg[1] = sto_cfg_t'(pwdata & 32'h03ffff3f);
         end else if (paddr == ADDR_TEST && pwdata <= 32'(TEST_MAX)) begin
            s_d.test_set = pwdata[19:0];
         end
      end

      // apb read data and error prepared in the setup phase
      s_d.rdata = 32'h00000000;
      s_d.err   = 1'b0;
      if (setup) begin
         if (paddr == ADDR_CFG_A) begin
            s_d.rdata = s_q.cfg[0];
         end else if (paddr == ADDR_CFG_B) begin
            s_d.rdata = s_q.cfg[1];
         end else if (paddr == ADDR_TEST) begin
            s_d.rdata = {12'h000, s_q.test_set};
            // an out-of-range setting is refused and flagged
            s_d.err   = pwrite & (pwdata > 32'(TEST_MAX));
         end else if (paddr == ADDR_CMD) begin
            s_d.rdata = 32'h00000000;
         end else if (paddr == ADDR_STATUS) begin
            s_d.rdata = {18'h00000, s_q.started, ext_fn, s_q.stop_pend,
                         s_q.fault, s_q.safety_msg, s_q.disc_done,
                         s_q.out.test_alarm, s_q.out.drive_on,
                         s_q.out.inhibit, s_q.out.brake_close,
                         s_q.out.pulse_off_b, s_q.out.pulse_off_a, s_q.sto_q};
         end else if (paddr == ADDR_TIMER) begin
            s_d.rdata = {12'h000, s_q.timer};
         end else begin
            s_d.err = 1'b1;                       // unmapped address
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q          <= '0;
         s_q.cfg      <= {CFG_RST, CFG_RST};
         s_q.test_set <= TEST_RST;
         s_q.timer    <= TEST_RST;
         s_q.sel      <= 2'b11;
         s_q.sto_q    <= 1'b1;                    // safe until started
         s_q.run      <= RUN_INHIBIT;
         // the on/off pin idles high; starting its flops low would
         // show a false rising edge right after reset
         s_q.sync1    <= 3'b100;
         s_q.sync2    <= 3'b100;
         s_q.on_off_q <= 1'b1;
         s_q.out      <= '{pulse_off_a: 1'b1, pulse_off_b: 1'b1,
                           pulse_suppress: 1'b1, coast_stop: 1'b1,
                           inhibit: 1'b1, default: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // checks run in the single clock domain
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_path_own_ch: assert property (
      s_q.started && term_en && s_q.deb_lvl[0] |=> drv.pulse_off_a)
      else $error("channel a path not asserted");
   chk_either_path: assert property (
      drv.pulse_suppress == (drv.pulse_off_a | drv.pulse_off_b))
      else $error("pulse suppression not or of paths");
   // only a deselection counts as a performed test
   chk_alarm_hold: assert property (
      drv.test_alarm && !sto_fall |=> drv.test_alarm)
      else $error("alarm dropped without test");
   chk_timer_reload: assert property (
      s_q.sto_q && !sto_now |=> s_q.timer == $past(s_q.test_set))
      else $error("timer not reloaded");
   chk_test_range: assert property (s_q.test_set <= TEST_MAX)
      else $error("test setting out of range");
   chk_inhibit_held: assert property (
      s_q.sto_q |-> drv.inhibit && !drv.drive_on)
      else $error("inhibit missing while selected");
   chk_no_autostart: assert property (
      drv.inhibit && !on_fall |=> drv.inhibit && !drv.drive_on)
      else $error("inhibit left without on/off edge");
   chk_coast_arm: assert property (
      s_q.sto_q |-> drv.coast_stop && !drv.arm_short)
      else $error("coast stop or armature short wrong");
   chk_deact_refuse: assert property (
      deact_req && any_en |=> deact_refused && !deact_done)
      else $error("deactivation not refused");
   // the startup latch may close right after, so one cycle is owed
   chk_startup_safe: assert property (
      !s_q.started |=> drv.pulse_suppress && drv.pulse_off_a &&
      drv.pulse_off_b)
      else $error("pulses released before startup");
   chk_stop_clear: assert property (
      s_q.sto_q && !sto_now |=> s_q.stop_pend == 2'b00 && !drv.brake_close)
      else $error("stops or brake kept after deselection");

   cov_select: cover property (!s_q.sto_q ##1 s_q.sto_q);
   cov_restart: cover property (drv.inhibit ##[1:50] drv.drive_on);
   cov_overdue: cover property ($rose(drv.test_alarm));
   cov_discrepancy: cover property (disc_hit);
endmodule
`default_nettype wire

// ===== verification/sto_ext_ctl.sv
// Purpose: model of the terminal wiring and the fieldbus controller
// Assumes: requests from the bench change on pclk
// Notes:   one request vector steers both selection paths
`timescale 1ns/1ns
`default_nettype none
module sto_ext_ctl (
   input  wire logic       pclk,          // bench clock
   input  wire logic [1:0] want,          // torque-off wanted, per channel
   input  wire logic       use_term,      // select through terminals
   input  wire logic       use_fb,        // select through fieldbus
   input  wire logic       run,           // on/off level wanted
   output logic            term_sel_n_a,  // channel a terminal, low sel
   output logic            term_sel_n_b,  // channel b terminal, low sel
   output logic [1:0]      fb_sel,        // fieldbus select per channel
   output logic            on_off_command // on/off pin
);
   // pins follow the request one edge later; with want at zero they
   // idle deselected from the first edge, well inside the bench reset
   // each channel has its own pin, so one channel can act alone
   always @(posedge pclk) begin
      term_sel_n_a <= ~(want[0] & use_term);
      term_sel_n_b <= ~(want[1] & use_term);
      fb_sel <= want & {2{use_fb}};
      on_off_command <= run;
   end
endmodule
`default_nettype wire

// ===== verification/safe_torque_off_controller_test.sv
// Purpose: self-checking bench for the torque-off controller
// Assumes: monitor and hundredth counts shortened to 4 and 3
// Notes:   drive outputs are sampled on the falling edge; bus answers
//          are taken at the rising edge that completes the access
`timescale 1ns/1ns
`default_nettype none
module safe_torque_off_controller_test;
   import sto_pkg::*;
   logic        pclk, pready, pslverr, er;        // clock, apb answer
   logic        presetn = 1'b0;                   // reset, held low
   logic        psel = 1'b0, penable = 1'b0;      // apb phases
   logic        pwrite = 1'b0;                    // apb direction
   logic [7:0]  paddr = 8'h00;                    // apb address
   logic [31:0] pwdata = 32'h0, prdata, rd;       // apb data
   logic        startup = 1'b0, brk = 1'b0;       // startup, brake
   logic        den = 1'b0, ash = 1'b0;           // enable, short req
   logic        dreq = 1'b0, ddone, dref;         // deactivate
   logic        run = 1'b1, ut = 1'b0, uf = 1'b0; // model controls
   logic        ta, tb, onoff;                    // pins from model
   logic [1:0]  fb, want = 2'b00;                 // selection
   sto_drive_t  drv;                              // drive outputs
   int          n_fail = 0, checked = 0;          // tallies

   sto_ctrl #(.MON_CYCLES(4), .HUNDREDTH_TICKS(3)) DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .term_sel_n_a(ta), .term_sel_n_b(tb),
      .fb_sel(fb), .startup_done(startup), .brake_present(brk),
      .drive_enable(den), .on_off_command(onoff), .arm_short_req(ash),
      .deact_req(dreq), .deact_done(ddone), .deact_refused(dref), .drv);
   sto_ext_ctl ext (.pclk, .want, .use_term(ut), .use_fb(uf), .run,
      .term_sel_n_a(ta), .term_sel_n_b(tb), .fb_sel(fb),
      .on_off_command(onoff));

   // 4 ns period
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // case equality, so an unknown never passes
   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic hang(input string what);
      n_fail++;
      $display("CHECK FAILED %s expected answer seen timeout", what);
      give_verdict();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge pclk);
   endtask
   task automatic sel(input logic [1:0] w);
      @(posedge pclk);
      want <= w;
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) hang("pready");
      // answer taken at the completing edge, before the slave updates
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // bounded wait on one bit of the drive outputs
   task automatic wait_drv(input int b, input logic v);
      for (int i = 0; i < 400; i++) begin
         @(negedge pclk);
         if (drv[b] === v) return;
      end
      hang("drive output");
   endtask
   task automatic s_regs();
      apb(1'b0, ADDR_TEST, 32'h0);
      chk("test setting reset", 32'h320, rd);
      apb(1'b1, ADDR_TEST, 32'hdbba1);
      chk("test setting over range", 1, er);
      apb(1'b1, ADDR_TEST, 32'hdbba0);
      apb(1'b0, ADDR_TEST, 32'h0);
      chk("test setting maximum", 32'hdbba0, rd);
      apb(1'b0, 8'h3c, 32'h0);
      chk("unmapped error", 1, er);
   endtask
   task automatic s_startup();
      apb(1'b1, ADDR_CFG_A, 32'h1);
      apb(1'b1, ADDR_CFG_B, 32'h1);
      cyc(10);
      chk("suppress before startup", 1, drv.pulse_suppress);
      @(posedge pclk);
      startup <= 1'b1;
      wait_drv(6, 1'b0);
   endtask
   // four enable patterns against terminal and fieldbus selection
   task automatic s_modes();
      logic [31:0] m [4] = '{32'h01, 32'h08, 32'h09, 32'h0c};
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, ADDR_CFG_A, m[k]);
         apb(1'b1, ADDR_CFG_B, m[k]);
         ut <= 1'b1;
         sel(2'b01);
         cyc(8);
         chk("terminal path a", m[k][0], drv.pulse_off_a);
         chk("either path suppress", m[k][0], drv.pulse_suppress);
         sel(2'b00);
         ut <= 1'b0;
         uf <= 1'b1;
         cyc(8);
         sel(2'b10);
         cyc(8);
         chk("fieldbus path b", m[k][3], drv.pulse_off_b);
         chk("path a untouched", 0, drv.pulse_off_a);
         sel(2'b00);
         uf <= 1'b0;
         cyc(8);
      end
   endtask
   task automatic s_stop_restart();
      apb(1'b1, ADDR_CFG_A, 32'h21);
      apb(1'b1, ADDR_CFG_B, 32'h21);
      apb(1'b1, ADDR_TEST, 32'h1);
      brk <= 1'b1;
      ash <= 1'b1;
      den <= 1'b1;
      ut <= 1'b1;
      sel(2'b11);
      wait_drv(6, 1'b1);
      cyc(2);
      chk("brake closed", 1, drv.brake_close);
      chk("coast stop", 1, drv.coast_stop);
      chk("short disabled", 0, drv.arm_short);
      chk("inhibit held", 1, drv.inhibit);
      sel(2'b00);
      wait_drv(6, 1'b0);
      chk("brake released", 0, drv.brake_close);
      cyc(10);
      chk("no restart", 0, drv.drive_on);
      @(posedge pclk);
      run <= 1'b0;
      wait_drv(4, 1'b0);
      @(posedge pclk);
      run <= 1'b1;
      wait_drv(1, 1'b1);
      wait_drv(0, 1'b1);
      cyc(4);
      chk("drive unaffected", 1, drv.drive_on);
      sel(2'b11);
      wait_drv(6, 1'b1);
      chk("alarm kept", 1, drv.test_alarm);
      sel(2'b00);
      wait_drv(6, 1'b0);
      chk("alarm reloaded", 0, drv.test_alarm);
   endtask
   // one channel selected over the fieldbus: fault class, then alarm
   // class with withdrawal; test alarm bit masked, its moment depends
   // on the hour prescaler
   task automatic s_disc();
      logic [31:0] cfg_a [2] = '{32'h02010009, 32'h01010019};
      logic [31:0] on_st [2] = '{32'h2e93, 32'h2193};
      logic [31:0] off_st [2] = '{32'h2210, 32'h2010};
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, ADDR_CFG_A, cfg_a[k]);
         apb(1'b1, ADDR_CFG_B, 32'h00010009);
         apb(1'b0, ADDR_CFG_B, 32'h0);
         chk("config b own word", 32'h00010009, rd);
         ut <= 1'b0;
         uf <= 1'b1;
         sel(2'b01);
         cyc(16);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk("status one channel", on_st[k], rd & ~32'h40);
         sel(2'b00);
         cyc(8);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk("status off", off_st[k], rd & ~32'h40);
         apb(1'b1, ADDR_CMD, 32'h1);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk("fault acknowledged", 0, rd[9]);
      end
   endtask
   task automatic s_deact();
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         dreq <= 1'b1;
         @(posedge pclk);
         dreq <= 1'b0;
         @(negedge pclk);
         chk("deactivate refused", k == 0, dref);
         chk("deactivate granted", k == 1, ddone);
         apb(1'b1, ADDR_CFG_A, 32'h0);
         apb(1'b1, ADDR_CFG_B, 32'h0);
      end
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      s_startup();
      s_modes();
      s_stop_restart();
      s_disc();
      s_deact();
      give_verdict();
   end
endmodule
`default_nettype wire
